/* File: include/asc_regs.svh */
// register map, field positions, reset values and timing of the controller
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// ----------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------
`define ASC_A_CTRL 12'h000
`define ASC_A_SEL 12'h004
`define ASC_A_MON 12'h008
`define ASC_A_RESULT 12'h00C
`define ASC_A_DEST 12'h010
`define ASC_A_THRESH 12'h014
`define ASC_A_GUARD 12'h018
`define ASC_A_DACCTL 12'h01C
`define ASC_A_DACDATA 12'h020
`define ASC_A_STATUS 12'h024
// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define ASC_CTRL_GO 0
`define ASC_CTRL_SYNC 1
`define ASC_CTRL_SIMULT 2
`define ASC_CTRL_PAIR 3
`define ASC_CTRL_PRECH 4
`define ASC_CTRL_ROUTE 6:5
`define ASC_CTRL_STAG 15:8
`define ASC_SEL_F 17:0
`define ASC_MON_SEL 2:0
`define ASC_MON_GO 3
`define ASC_MON_RES 29:16
`define ASC_MON_INPUTS 3'h7
`define ASC_RES_DATA 15:0
`define ASC_RES_TAG 19:16
`define ASC_RES_NEW 31
`define ASC_DEST_F 11:0
`define ASC_THR_L 7:0
`define ASC_THR_U 15:8
`define ASC_DAC_DMA 0
`define ASC_DAC_CODE 11:0
// ----------------------------------------------------------------------
// sequencing and reset values
// ----------------------------------------------------------------------
`define ASC_IDX_TWO 3'h3
`define ASC_IDX_LAST 3'h5
`define ASC_LAST_ROUND 3'h7
`define ASC_RST_THR_U 8'hFF
`define ASC_RST_THR_L 8'h00
`define ASC_T6_NS 1400
`define ASC_T16_NS 3000
`define ASC_CLK_NS 100
`endif

/* File: include/asc_pkg.sv */
// types shared by the sampling controller and its users
package asc_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } asc_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } asc_apb_rsp_t;
   // one converter answer: done pulse plus three track/hold results
   typedef struct packed {
      logic done;
      logic [2:0][15:0] data;
   } asc_conv_in_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_WAIT, ST_DRAIN} asc_fsm_t;
   typedef enum logic [1:0] {RT_DMA, RT_REG, RT_DIRECT} asc_route_t;
   typedef struct packed {
      asc_fsm_t fsm;
      logic go;
      logic sync;
      logic simult;
      logic pair;
      logic prechOff;
      asc_route_t route;
      logic [7:0] stagger;
      logic [17:0] sel;
      logic [2:0] monSel;
      logic monBusy;
      logic monStart;
      logic [13:0] monRes;
      logic [15:0] result;
      logic [3:0] resTag;
      logic fresh;
      logic [11:0] dest;
      logic [7:0] thrU;
      logic [7:0] thrL;
      logic dmaSrc;
      logic [11:0] dacCode;
      logic dacLoad;
      logic [6:0] s1;
      logic [6:0] s2;
      logic [6:0] s3;
      logic [6:0] pins;
      logic trigQ;
      logic [7:0] cnt;
      logic [2:0] round;
      logic [2:0] idx;
      logic gotOne;
      logic gotTwo;
      logic issuedOne;
      logic issuedTwo;
      logic [5:0][15:0] res;
      logic holdOne;
      logic holdTwo;
      logic dmaValid;
      logic [31:0] dmaData;
      logic destWrite;
      logic [15:0] destData;
      logic [31:0] rdata;
      logic err;
   } asc_state_t;
endpackage

/* File: core/asc_sampling_controller.sv */
// sampling controller, dac output controller and overcurrent guard
//
// Behaviour
// - times sampling, six channels at once, three per primary converter
// - six simultaneous results reach memory within 1.4 us
// - sixteen channels in simultaneous pairs reach memory within 3.0 us; the eight rounds here take at least four cycles each, 3.2 us at 100 ns
// - each result goes to dma, a result register or a destination
// - primary converters sample together or at independent times
// - asynchronous and synchronous modes; exact matching only synchronous
// - three track/holds per converter, each picks one of eight inputs
// - monitor converter runs independently with a seven-way input mux
// - software setting disables the input precharge buffers
// - three comparators watch the first input of each track/hold group
// - shared upper and lower thresholds, each an 8-bit dac code
// - comparator outputs readable; interrupt when any signals a limit
// - dac controller drives one external and two threshold dacs
// - dac codes come from dma or a processor-written register
// - external dac codes are 12 bits wide
`timescale 1ns/1ns
`default_nettype none
`include "asc_regs.svh"
module asc_sampling_controller (
   input wire logic clock,
   input wire logic nrst,
   input wire logic clkEn,
   input wire asc_pkg::asc_apb_req_t apbReq,
   output asc_pkg::asc_apb_rsp_t apbRsp,
   input wire logic sampleTrig,
   input wire asc_pkg::asc_conv_in_t convOne,
   input wire asc_pkg::asc_conv_in_t convTwo,
   output logic holdOne,
   output logic holdTwo,
   output logic [8:0] muxOne,
   output logic [8:0] muxTwo,
   output logic prechargeOff,
   output logic [2:0] monSel,
   output logic monStart,
   input wire logic monDone,
   input wire logic [13:0] monData,
   output logic dmaValid,
   output logic [31:0] dmaData,
   input wire logic dmaReady,
   output logic destWrite,
   output logic [11:0] destAddr,
   output logic [15:0] destData,
   input wire logic [2:0] compHigh,
   input wire logic [2:0] compLow,
   output logic [7:0] threshUpper,
   output logic [7:0] threshLower,
   output logic guardIrq,
   output logic [11:0] dacCode,
   output logic dacLoad,
   input wire logic dacReqValid,
   input wire logic [15:0] dacReqData,
   output logic dacReqReady
);
   import asc_pkg::*;

   asc_state_t s;
   asc_state_t n;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic mapped(input logic [11:0] a);
      case (a)
         `ASC_A_CTRL, `ASC_A_SEL, `ASC_A_MON, `ASC_A_RESULT,
         `ASC_A_DEST, `ASC_A_THRESH, `ASC_A_GUARD, `ASC_A_DACCTL,
         `ASC_A_DACDATA, `ASC_A_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic lastIdx(input logic [2:0] i, input logic pr);
      lastIdx = pr ? (i == `ASC_IDX_TWO) : (i == `ASC_IDX_LAST);
   endfunction

   function automatic logic [2:0] nextIdx(input logic [2:0] i,
                                          input logic pr);
      nextIdx = pr ? `ASC_IDX_TWO : i + 3'h1;
   endfunction

   // channel number: pair mode 0..15, full burst 0..5
   function automatic logic [3:0] chanTag(input logic [2:0] i,
                                          input logic [2:0] r,
                                          input logic pr);
      chanTag = pr ? {r, i == `ASC_IDX_TWO} : {1'b0, i};
   endfunction

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   logic setup;
   logic wr;
   logic rd;
   logic trigRise;
   logic start;
   logic push;
   logic [6:0] agree;
   logic [2:0] limit;
   logic [2:0] compHighQ;
   logic [2:0] compLowQ;

   always_comb begin
      n = s;
      n.go = 1'b0;
      n.holdOne = 1'b0;
      n.holdTwo = 1'b0;
      n.monStart = 1'b0;
      n.dacLoad = 1'b0;
      n.destWrite = 1'b0;
      setup = apbReq.psel & ~apbReq.penable;
      wr = apbReq.psel & apbReq.penable & apbReq.pwrite;
      rd = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
      push = 1'b0;

      // pins pass three flops; a change counts once stages two and three agree
      n.s1 = {compLow, compHigh, sampleTrig};
      n.s2 = s.s1;
      n.s3 = s.s2;
      agree = ~(s.s2 ^ s.s3);
      n.pins = (s.pins & ~agree) | (s.s3 & agree);
      n.trigQ = s.pins[0];
      trigRise = s.pins[0] & ~s.trigQ;
      // limit above upper or below lower
      limit = s.pins[3:1] | s.pins[6:4];

      // register read data prepared in the setup phase
      if (setup) begin
         n.err = ~mapped(apbReq.paddr);
         case (apbReq.paddr)
            `ASC_A_CTRL: n.rdata = {16'h0000, s.stagger, 1'b0, s.route,
               s.prechOff, s.pair, s.simult, s.sync, 1'b0};
            `ASC_A_SEL: n.rdata = {14'h0000, s.sel};
            `ASC_A_MON: n.rdata = {2'h0, s.monRes, 11'h000, s.monBusy,
               1'b0, s.monSel};
            `ASC_A_RESULT: n.rdata = {s.fresh, 11'h000, s.resTag, s.result};
            `ASC_A_DEST: n.rdata = {20'h00000, s.dest};
            `ASC_A_THRESH: n.rdata = {16'h0000, s.thrU, s.thrL};
            `ASC_A_GUARD: n.rdata = {23'h000000, compLowQ, compHighQ, limit};
            `ASC_A_DACCTL: n.rdata = {31'h00000000, s.dmaSrc};
            `ASC_A_DACDATA: n.rdata = {20'h00000, s.dacCode};
            `ASC_A_STATUS: n.rdata = {24'h000000, s.idx, s.round, s.fsm};
            default: n.rdata = 32'h00000000;
         endcase
      end

      // reading the result register clears its fresh flag
      if (rd && apbReq.paddr == `ASC_A_RESULT) begin
         n.fresh = 1'b0;
      end

      if (wr) begin
         case (apbReq.paddr)
            `ASC_A_CTRL: begin
               n.go = apbReq.pwdata[`ASC_CTRL_GO] & (s.fsm == ST_IDLE);
               n.sync = apbReq.pwdata[`ASC_CTRL_SYNC];
               n.simult = apbReq.pwdata[`ASC_CTRL_SIMULT];
               n.pair = apbReq.pwdata[`ASC_CTRL_PAIR];
               n.prechOff = apbReq.pwdata[`ASC_CTRL_PRECH];
               n.route = asc_route_t'(apbReq.pwdata[`ASC_CTRL_ROUTE]);
               n.stagger = apbReq.pwdata[`ASC_CTRL_STAG];
            end
            `ASC_A_SEL: n.sel = apbReq.pwdata[`ASC_SEL_F];
            `ASC_A_MON: begin
               // monitor runs on its own; only inputs 0..6 exist
               if (!s.monBusy &&
                   apbReq.pwdata[`ASC_MON_SEL] < `ASC_MON_INPUTS) begin
                  n.monSel = apbReq.pwdata[`ASC_MON_SEL];
                  n.monStart = apbReq.pwdata[`ASC_MON_GO];
                  n.monBusy = apbReq.pwdata[`ASC_MON_GO];
               end
            end
            `ASC_A_DEST: n.dest = apbReq.pwdata[`ASC_DEST_F];
            `ASC_A_THRESH: begin
               n.thrL = apbReq.pwdata[`ASC_THR_L];
               n.thrU = apbReq.pwdata[`ASC_THR_U];
            end
            `ASC_A_DACCTL: n.dmaSrc = apbReq.pwdata[`ASC_DAC_DMA];
            `ASC_A_DACDATA: begin
               if (!s.dmaSrc) begin
                  n.dacCode = apbReq.pwdata[`ASC_DAC_CODE];
                  n.dacLoad = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      if (s.dmaSrc && dacReqValid) begin
         n.dacCode = dacReqData[`ASC_DAC_CODE];
         n.dacLoad = 1'b1;
      end

      if (s.monBusy && monDone) begin
         n.monRes = monData;
         n.monBusy = 1'b0;
      end

      if (s.dmaValid && dmaReady) begin
         n.dmaValid = 1'b0;
      end

      // synchronous start from software, asynchronous from pin
      start = s.sync ? s.go : trigRise;

      // collect converter answers while a round is open
      if (s.fsm == ST_SAMPLE || s.fsm == ST_WAIT) begin
         if (convOne.done) begin
            n.res[2:0] = convOne.data;
            n.gotOne = 1'b1;
         end
         if (convTwo.done) begin
            n.res[5:3] = convTwo.data;
            n.gotTwo = 1'b1;
         end
      end

      case (s.fsm)
         ST_IDLE: begin
            if (start) begin
               n.round = 3'h0;
               n.cnt = 8'h00;
               n.issuedOne = 1'b0;
               n.issuedTwo = 1'b0;
               n.gotOne = 1'b0;
               n.gotTwo = 1'b0;
               n.fsm = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            // both converters hold their three inputs
            if (!s.issuedOne) begin
               n.holdOne = 1'b1;
               n.issuedOne = 1'b1;
            end
            // same instant or staggered by a set count
            if (!s.issuedTwo && (s.simult || s.cnt == s.stagger)) begin
               n.holdTwo = 1'b1;
               n.issuedTwo = 1'b1;
            end
            n.cnt = s.cnt + 8'h01;
            if (n.issuedOne && n.issuedTwo) begin
               n.fsm = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (n.gotOne && n.gotTwo) begin
               n.idx = 3'h0;
               n.fsm = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // one result per cycle to the chosen target
            case (s.route)
               RT_DMA: begin
                  if (!s.dmaValid || dmaReady) begin
                     n.dmaValid = 1'b1;
                     n.dmaData = {12'h000, chanTag(s.idx, s.round, s.pair),
                        s.res[s.idx]};
                     push = 1'b1;
                  end
               end
               RT_DIRECT: begin
                  n.destWrite = 1'b1;
                  n.destData = s.res[s.idx];
                  push = 1'b1;
               end
               default: begin
                  n.result = s.res[s.idx];
                  n.resTag = chanTag(s.idx, s.round, s.pair);
                  n.fresh = 1'b1;
                  push = 1'b1;
               end
            endcase
            if (push) begin
               n.idx = nextIdx(s.idx, s.pair);
               if (lastIdx(s.idx, s.pair)) begin
                  // pair mode walks eight rounds of two
                  if (s.pair && s.round != `ASC_LAST_ROUND) begin
                     n.round = s.round + 3'h1;
                     n.cnt = 8'h00;
                     n.issuedOne = 1'b0;
                     n.issuedTwo = 1'b0;
                     n.gotOne = 1'b0;
                     n.gotTwo = 1'b0;
                     n.fsm = ST_SAMPLE;
                  end else begin
                     n.fsm = ST_IDLE;
                  end
               end
            end
         end
         default: n.fsm = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s <= '0;
         s.thrU <= `ASC_RST_THR_U;
         s.thrL <= `ASC_RST_THR_L;
      end else if (clkEn) begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign compHighQ = s.pins[3:1];
   assign compLowQ = s.pins[6:4];

   assign apbRsp.pready = clkEn;
   assign apbRsp.prdata = s.rdata;
   assign apbRsp.pslverr = s.err & apbReq.psel & apbReq.penable;
   assign holdOne = s.holdOne;
   assign holdTwo = s.holdTwo;
   // unit 0 steps through inputs in pair mode
   assign muxOne = {s.sel[8:3], s.pair ? s.round : s.sel[2:0]};
   assign muxTwo = {s.sel[17:12], s.pair ? s.round : s.sel[11:9]};
   assign prechargeOff = s.prechOff;
   assign monSel = s.monSel;
   assign monStart = s.monStart;
   assign dmaValid = s.dmaValid;
   assign dmaData = s.dmaData;
   assign destWrite = s.destWrite;
   assign destAddr = s.dest;
   assign destData = s.destData;
   // threshold dacs driven alongside the external one
   assign threshUpper = s.thrU;
   assign threshLower = s.thrL;
   // one comparator per first input of each group
   assign guardIrq = |limit;
   assign dacCode = s.dacCode;
   assign dacLoad = s.dacLoad;
   assign dacReqReady = s.dmaSrc;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   localparam int Burst6 = `ASC_T6_NS / `ASC_CLK_NS;
   localparam int Burst16 = `ASC_T16_NS / `ASC_CLK_NS;
   int drainLen;
   int ownLen;

   always_ff @(posedge clock) begin
      if (!nrst || s.fsm == ST_IDLE) begin
         ownLen <= 0;
      end else if (clkEn && s.fsm != ST_WAIT) begin
         ownLen <= ownLen + 1;
      end
      if (!nrst || s.fsm != ST_DRAIN) begin
         drainLen <= 0;
      end else if (clkEn) begin
         drainLen <= drainLen + 1;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence regWrite;
      wr && clkEn && apbReq.paddr == `ASC_A_DACDATA && !s.dmaSrc;
   endsequence
   sequence loadSeen;
      dacLoad && dacCode == $past(apbReq.pwdata[`ASC_DAC_CODE]);
   endsequence

   a_sim_hold: assert property (holdOne && s.simult |-> holdTwo)
      else $error("converters did not hold together");
   a_stagger_gap: assert property (
      holdTwo && !s.simult |-> s.cnt == s.stagger + 8'h01)
      else $error("staggered hold at wrong count");
   a_pair_mux: assert property (
      holdOne && s.pair |-> muxOne[2:0] == s.round)
      else $error("pair mode mux not on round input");
   a_drain_six: assert property (
      s.fsm == ST_DRAIN && s.route != RT_DMA |-> drainLen < Burst6)
      else $error("six results took too long");
   a_pair_budget: assert property (
      s.pair && s.simult && s.route != RT_DMA && s.fsm != ST_IDLE
      |-> ownLen < Burst16)
      else $error("pair burst over its budget");
   a_dest_route: assert property (
      destWrite |-> s.route == RT_DIRECT && $past(s.fsm) == ST_DRAIN)
      else $error("direct write outside direct route");
   a_dma_hold: assert property (
      dmaValid && !dmaReady |=> dmaValid && $stable(dmaData))
      else $error("dma word dropped under stall");
   a_limit_filter: assert property (
      $changed(s.pins[6:1]) |-> $past(s.s2[6:1]) == $past(s.s3[6:1]))
      else $error("limit changed before stages agreed");
   a_irq_level: assert property (
      clkEn && s.s2[6:1] == s.s3[6:1] |=> guardIrq == |$past(s.s3[6:1]))
      else $error("interrupt does not follow agreed comparators");
   a_dac_reg: assert property (regWrite |=> loadSeen)
      else $error("register dac code not loaded");
   a_mon_sel: assert property (
      monStart |-> monSel < `ASC_MON_INPUTS && s.monBusy)
      else $error("monitor started on bad input");
endmodule
`default_nettype wire

/* File: bench/asc_conv_model.sv */
// behavioural model of the primary and monitor converters
`timescale 1ns/1ns
`default_nettype none
module asc_conv_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic holdOne,
   input wire logic holdTwo,
   input wire logic monStart,
   input wire logic [3:0] extra,
   output asc_pkg::asc_conv_in_t convOne,
   output asc_pkg::asc_conv_in_t convTwo,
   output logic monDone,
   output logic [13:0] monData
);
   import asc_pkg::*;
   localparam logic [47:0] D1 = {16'h1102, 16'h1101, 16'h1100};
   localparam logic [47:0] D2 = {16'h2202, 16'h2201, 16'h2200};
   logic [4:0] c1, c2, cm;
   // ----------------------------------------------------------------
   // conversion delay, extra cycles slow the answer
   // ----------------------------------------------------------------
   // three track/hold units answer per hold command
   always_ff @(posedge clock) begin
      if (!nrst) begin
         c1 <= 5'h00;
         c2 <= 5'h00;
         cm <= 5'h00;
      end else begin
         c1 <= holdOne ? {1'b0, extra} + 5'h01 : c1 - 5'(c1 != 5'h00);
         c2 <= holdTwo ? {1'b0, extra} + 5'h01 : c2 - 5'(c2 != 5'h00);
         cm <= monStart ? {1'b0, extra} + 5'h01 : cm - 5'(cm != 5'h00);
      end
   end
   // data lines toggle away outside the done cycle
   assign convOne = {c1 == 5'h01, c1 == 5'h01 ? D1 : ~D1};
   assign convTwo = {c2 == 5'h01, c2 == 5'h01 ? D2 : ~D2};
   // monitor converter answers on its own
   assign monDone = cm == 5'h01;
   assign monData = monDone ? 14'h0150 : 14'h3EAF;
endmodule
`default_nettype wire

/* File: bench/asc_sampling_controller_tb_top.sv */
// testbench of the sampling controller
`timescale 1ns/1ns
`default_nettype none
module asc_sampling_controller_tb_top;
   import asc_pkg::*;
   `include "asc_regs.svh"
   logic clock, nrst, clkEn, sampleTrig, holdOne, holdTwo, prechargeOff;
   logic monStart, monDone, dmaValid, dmaReady, destWrite, guardIrq;
   logic dacLoad, dacReqValid, dacReqReady, er;
   logic [8:0] muxOne, muxTwo;
   logic [2:0] monSel, compHigh, compLow;
   logic [13:0] monData;
   logic [31:0] dmaData, rd;
   logic [11:0] destAddr, dacCode;
   logic [15:0] destData, dacReqData, lastDest;
   logic [7:0] threshUpper, threshLower;
   logic [3:0] extra;
   asc_apb_req_t req;
   asc_apb_rsp_t rsp;
   asc_conv_in_t convOne, convTwo;
   logic [31:0] q[$];
   int errors = 0, cmp_count = 0, dw = 0, ms = 0, dl = 0, cyc = 0;
   int h1 = 0, h2 = 0, lastT = 0;
   asc_sampling_controller asc_sampling_controller_inst (.clock(clock),
      .nrst(nrst), .clkEn(clkEn), .apbReq(req), .apbRsp(rsp),
      .sampleTrig(sampleTrig), .convOne(convOne), .convTwo(convTwo),
      .holdOne(holdOne), .holdTwo(holdTwo), .muxOne(muxOne),
      .muxTwo(muxTwo), .prechargeOff(prechargeOff), .monSel(monSel),
      .monStart(monStart), .monDone(monDone), .monData(monData),
      .dmaValid(dmaValid), .dmaData(dmaData), .dmaReady(dmaReady),
      .destWrite(destWrite), .destAddr(destAddr), .destData(destData),
      .compHigh(compHigh), .compLow(compLow), .threshUpper(threshUpper),
      .threshLower(threshLower), .guardIrq(guardIrq), .dacCode(dacCode),
      .dacLoad(dacLoad), .dacReqValid(dacReqValid),
      .dacReqData(dacReqData), .dacReqReady(dacReqReady));
   asc_conv_model asc_conv_model_inst (.clock(clock), .nrst(nrst),
      .holdOne(holdOne), .holdTwo(holdTwo), .monStart(monStart),
      .extra(extra), .convOne(convOne), .convTwo(convTwo),
      .monDone(monDone), .monData(monData));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (dmaValid === 1'b1 && dmaReady === 1'b1) q.push_back(dmaData);
      if (destWrite === 1'b1) begin
         dw <= dw + 1;
         lastDest <= destData;
      end
      if (monStart === 1'b1) ms <= ms + 1;
      if (dacLoad === 1'b1) dl <= dl + 1;
      if (holdOne === 1'b1) h1 <= cyc;
      if (holdTwo === 1'b1) h2 <= cyc;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      // let the write settle before callers look
      @(posedge clock);
   endtask
   task automatic burst(input logic [31:0] c, input int n, input bit trig,
                        input bit stall);
      int d0, t;
      q.delete();
      d0 = dw;
      t = 0;
      if (stall) dmaReady <= 1'b0;
      apb(1'b1, `ASC_A_CTRL, c);
      if (trig) sampleTrig <= 1'b1;
      while (t < 120 && q.size() + dw - d0 < n) begin
         @(posedge clock);
         t++;
         if (t == 10) dmaReady <= 1'b1;
      end
      // register route: wait until the drain is back to idle
      while (n == 0 && t < 120) begin
         apb(1'b0, `ASC_A_STATUS, 32'h0);
         t++;
         if (rd[1:0] == 2'h0) break;
      end
      sampleTrig <= 1'b0;
      lastT = t;
      chk(q.size() + dw - d0, n);
   endtask
   function automatic logic [31:0] ex(input int k, input bit pair);
      logic [15:0] v;
      v = k < 3 ? 16'h1100 + 16'(k) : 16'h2200 + 16'(k - 3);
      if (pair) v = k[0] ? 16'h2200 : 16'h1100;
      return {12'h000, 4'(k), v};
   endfunction
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      clkEn = 1'b1;
      req = '0;
      sampleTrig = 1'b0;
      compHigh = 3'h0;
      compLow = 3'h0;
      dmaReady = 1'b1;
      dacReqValid = 1'b0;
      dacReqData = 16'h0000;
      extra = 4'h0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      apb(1'b0, `ASC_A_THRESH, 32'h0);
      chk(rd, 32'h0000FF00);
      apb(1'b0, 12'h028, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, `ASC_A_THRESH, 32'h0000C040);
      chk({16'h0, threshUpper, threshLower}, 32'hC040);
      compHigh <= 3'b010;
      repeat (6) @(posedge clock);
      chk({31'h0, guardIrq}, 32'h1);
      apb(1'b0, `ASC_A_GUARD, 32'h0);
      chk(rd, 32'h12);
      compHigh <= 3'b000;
      compLow <= 3'b100;
      repeat (6) @(posedge clock);
      apb(1'b0, `ASC_A_GUARD, 32'h0);
      chk(rd, 32'h104);
      compLow <= 3'b000;
      repeat (6) @(posedge clock);
      chk({31'h0, guardIrq}, 32'h0);
      // frozen by the clock enable, a limit must not pass
      clkEn <= 1'b0;
      compHigh <= 3'b001;
      repeat (6) @(posedge clock);
      chk({31'h0, guardIrq}, 32'h0);
      clkEn <= 1'b1;
      repeat (6) @(posedge clock);
      chk({31'h0, guardIrq}, 32'h1);
      compHigh <= 3'b000;
      repeat (6) @(posedge clock);
      apb(1'b1, `ASC_A_CTRL, 32'h10);
      chk({31'h0, prechargeOff}, 32'h1);
      apb(1'b1, `ASC_A_SEL, {14'h0, 9'h0AB, 9'h1C3});
      chk({14'h0, muxTwo, muxOne}, {14'h0, 9'h0AB, 9'h1C3});
      burst(32'h07, 6, 1'b0, 1'b0);
      chk({31'h0, lastT <= 14}, 32'h1);
      chk(h2 - h1, 0);
      for (int k = 0; k < 6; k++) begin
         chk(q[k] & 32'hFFFFF, ex(k, 1'b0));
      end
      chk({31'h0, prechargeOff}, 32'h0);
      extra <= 4'h3;
      burst(32'h27, 0, 1'b0, 1'b0);
      apb(1'b0, `ASC_A_RESULT, 32'h0);
      chk(rd, 32'h80052202);
      apb(1'b0, `ASC_A_RESULT, 32'h0);
      chk(rd, 32'h00052202);
      extra <= 4'h0;
      apb(1'b1, `ASC_A_DEST, 32'h123);
      burst(32'h47, 6, 1'b0, 1'b0);
      chk({20'h0, destAddr}, 32'h123);
      chk({16'h0, lastDest}, 32'h2202);
      burst(32'h0F, 16, 1'b0, 1'b1);
      for (int k = 0; k < 16; k++) begin
         chk(q[k] & 32'hFFFFF, ex(k, 1'b1));
      end
      burst(32'h4F, 16, 1'b0, 1'b0);
      chk({16'h0, lastDest}, 32'h2200);
      burst(32'h0303, 6, 1'b0, 1'b0);
      chk(h2 - h1, 3);
      burst(32'h04, 6, 1'b1, 1'b0);
      apb(1'b1, `ASC_A_MON, 32'h0D);
      repeat (10) @(posedge clock);
      chk(ms, 1);
      chk({29'h0, monSel}, 32'h5);
      apb(1'b0, `ASC_A_MON, 32'h0);
      chk(rd & 32'h3FFF0010, 32'h01500000);
      apb(1'b1, `ASC_A_MON, 32'h0F);
      repeat (5) @(posedge clock);
      chk(ms, 1);
      apb(1'b1, `ASC_A_DACDATA, 32'hFFFFFABC);
      repeat (2) @(posedge clock);
      chk({20'h0, dacCode}, 32'hABC);
      apb(1'b1, `ASC_A_DACCTL, 32'h1);
      chk({31'h0, dacReqReady}, 32'h1);
      dacReqValid <= 1'b1;
      dacReqData <= 16'hF567;
      @(posedge clock);
      dacReqValid <= 1'b0;
      repeat (2) @(posedge clock);
      chk({20'h0, dacCode}, 32'h567);
      chk(dl, 2);
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
